// file: rtl/teq_pkg.sv
// constants for the touch event qualifier
// assumes one 100 MHz clock and a byte-wide register port
//
// Notes on behaviour
// - after the programmed count of negative deltas in a row, recalibrate that input.
// - while a negative-delta recalibration runs, that input reports no touch.
// - with hold limit enabled, recalibrate an input touched longer than the limit.
// - the hold-limit timer only runs while the delta is above threshold.
// - on the power button the hold-limit timer starts after qualification.
// - one input is the power button, with own hold times and enables per state.
// - power button needs the input enabled; mixed state uses standby settings if pwr_stby_en is set, else active ones.
// - a qualified power button sets the hold-button flag and interrupts.
// - a count or set of inputs over pattern threshold or noisy flags a pattern.
// - during a pattern event all touches are blocked.
// - low-frequency noise discards the sample and blocks the touch by default.
// - radio noise drops the sample from threshold comparison by default.
// - noise flag shows any analog noise, or only radio noise when selected.
// - over noise threshold but under touch threshold is a noise spike.
// - with spike discard set, spikes are kept out of recalibration averaging.
// - any interrupt event sets the pending bit and pulls the alert pin low.
// - host clears pending bit; pin releases and the hold-button and pattern flags clear.
// - enabled non-power inputs interrupt on touch and optionally on release.
// - repeat inputs time a minimum press; early release is a simple touch.
// - press-and-hold interrupts at the repeat rate until release.
// - the power button gets no immediate touch interrupt and no repeat.
// - mixed state senses active and standby inputs with their own settings.
// - automatic recalibration averages the last 64 accepted measurements.

package teq_pkg;
  // ==========================================================
  // sizes and timing
  localparam int N_IN = 3;
  localparam int AVG_DEPTH = 64;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int TICK_W = 17;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_MAIN_CTL = 8'h00;
  localparam logic [7:0] ADDR_GEN_STATUS = 8'h02;
  localparam logic [7:0] ADDR_INPUT_STATUS = 8'h03;
  localparam logic [7:0] ADDR_NOISE_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'h20;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h27;
  localparam logic [7:0] ADDR_REPEAT_ENABLE = 8'h28;
  localparam logic [7:0] ADDR_SECONDARY_CONFIG = 8'h44;

  // ==========================================================
  // reset values and write mask
  localparam logic [7:0] GEN_CFG_RST = 8'h20;
  localparam logic [7:0] SEC_CFG_RST = 8'h00;
  localparam logic [7:0] INT_EN_RST = 8'h07;
  localparam logic [7:0] RPT_EN_RST = 8'h07;
  localparam logic [7:0] INPUT_MASK = 8'h07;

  // ==========================================================
  // field positions
  localparam int MAIN_INT_BIT = 0;
  localparam int STAT_TOUCH_BIT = 0;
  localparam int STAT_MTP_BIT = 1;
  localparam int STAT_HOLD_BIT = 4;
  localparam int GCFG_HOLD_EN_BIT = 3;
  localparam int GCFG_ANA_BLOCK_BIT = 4;
  localparam int GCFG_SPIKE_BIT = 5;
  localparam int SCFG_REL_N_BIT = 0;
  localparam int SCFG_RF_BLOCK_BIT = 2;
  localparam int SCFG_RADIO_ONLY_BIT = 7;
endpackage : teq_pkg

// file: rtl/teq_avg.sv
// running average of accepted deltas for one input
// assumes sample_ok is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none

module teq_avg import teq_pkg::*; #(
  parameter int W = 8,
  parameter int N = AVG_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // accepted sample
  input wire logic sample_ok,
  input wire logic [W-1:0] sample_delta,
  // baseline correction
  output logic adj_valid,
  output logic [W-1:0] adj
);
  localparam int LG = $clog2(N);

  typedef struct packed {
    logic [W+LG-1:0] sum;
    logic [LG-1:0] cnt;
    logic vld;
    logic [W-1:0] adj;
  } teq_avg_state_t;

  teq_avg_state_t s;
  teq_avg_state_t n;

  // ==========================================================
  // accumulate, emit the mean every N accepted samples
  always_comb begin
    n = s;
    n.vld = 1'b0;
    if (sample_ok) begin
      n.sum = s.sum + (W+LG)'($signed(sample_delta));
      n.cnt = s.cnt + 1'b1;
      if (s.cnt == LG'(N-1)) begin
        n.adj = n.sum[W+LG-1:LG];
        n.vld = 1'b1;
        n.sum = '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign adj_valid = s.vld;
  assign adj = s.adj;
endmodule : teq_avg

`default_nettype wire

// file: rtl/teq_qualifier.sv
// touch event qualification, noise rejection and alert generation
// assumes measurements arrive from logic on sys_clk, one input per pulse
`timescale 1ns/1ps
`default_nettype none

module teq_qualifier import teq_pkg::*; #(
  parameter int TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS,
  parameter logic [15:0] HOLD_STEP_MS = 16'h01f4,
  parameter logic [15:0] PRESS_STEP_MS = 16'h0023,
  parameter logic [15:0] RPT_STEP_MS = 16'h0023,
  parameter logic [15:0] PWR_STEP_MS = 16'h0118
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // settings held elsewhere in the register map
  input wire logic in_standby,
  input wire logic mixed_state,
  input wire logic [N_IN-1:0] active_en,
  input wire logic [N_IN-1:0] standby_en,
  input wire logic [N_IN*8-1:0] active_thr,
  input wire logic [7:0] standby_thr,
  input wire logic [7:0] noise_thr,
  input wire logic [1:0] negative_reading_limit,
  input wire logic [3:0] hold_limit_field,
  input wire logic [3:0] min_hold_timer_field,
  input wire logic [3:0] repeat_rate_field,
  input wire logic [1:0] pwr_sel,
  input wire logic pwr_stby_en,
  input wire logic pwr_act_en,
  input wire logic [1:0] pwr_stby_time,
  input wire logic [1:0] pwr_act_time,
  input wire logic mtp_en,
  input wire logic mtp_by_pattern,
  input wire logic [N_IN-1:0] multi_touch_pattern,
  input wire logic [1:0] mtp_min_count,
  input wire logic [7:0] mtp_thr,
  input wire logic mtp_irq_en,
  // measurements
  input wire logic sample_valid,
  input wire logic [1:0] sample_idx,
  input wire logic [7:0] sample_delta,
  input wire logic lf_noise,
  input wire logic rf_noise,
  input wire logic [N_IN-1:0] recal_done,
  // results
  output logic alert_n,
  output logic [N_IN-1:0] recal_req,
  output logic [N_IN-1:0] base_adj_valid,
  output logic [N_IN*8-1:0] base_adj
);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [7:0] gen_cfg;
    logic [7:0] sec_cfg;
    logic [7:0] int_en;
    logic [7:0] rpt_en;
    logic [7:0] rd_data;
    logic int_pend;
    logic alert_n;
    logic hold_flag;
    logic mtp_flag;
    logic mtp_active;
    logic [N_IN-1:0] touch;
    logic [N_IN-1:0] noise;
    logic [N_IN-1:0] mtp_hit;
    logic [N_IN-1:0] neg_busy;
    logic [N_IN-1:0] held;
    logic [N_IN-1:0] recal_req;
    logic pwr_done;
    logic [N_IN-1:0][1:0] neg_cnt;
    logic [N_IN-1:0][15:0] hold_ms;
    logic [N_IN-1:0][15:0] press_ms;
    logic [15:0] pwr_ms;
  } teq_state_t;

  teq_state_t s;
  teq_state_t n;

  // ==========================================================
  // helpers
  function automatic logic [15:0] dur_ms(input logic [3:0] f,
                                         input logic [15:0] step);
    dur_ms = 16'(({12'h000, f} + 16'h0001) * step);
  endfunction : dur_ms

  function automatic logic [1:0] ones3(input logic [N_IN-1:0] v);
    ones3 = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction : ones3

  // ==========================================================
  // per-input decode of the shared sample
  logic [N_IN-1:0] in_use;
  logic [N_IN-1:0] above;
  logic [N_IN-1:0] spike;
  logic [N_IN-1:0] mtp_over;
  logic [N_IN-1:0] is_pwr;
  logic [N_IN-1:0] avg_ok;
  logic discard;
  logic nflag;
  logic pwr_use_stby;
  logic pwr_on;
  logic [15:0] pwr_time;

  // mixed state: active settings win for inputs enabled in both
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_in
      logic use_act;
      logic use_stb;
      logic [7:0] thr;
      logic hit;
      assign use_act = active_en[g] & (mixed_state | ~in_standby);
      assign use_stb = standby_en[g] &
                       (mixed_state ? ~active_en[g] : in_standby);
      assign in_use[g] = use_act | use_stb;
      assign thr = use_act ? active_thr[g*8 +: 8] : standby_thr;
      assign above[g] = $signed(sample_delta) > $signed({1'b0, thr});
      assign spike[g] = ($signed(sample_delta) > $signed({1'b0, noise_thr}))
                        & ~above[g];
      assign mtp_over[g] = $signed(sample_delta) > $signed({1'b0, mtp_thr});
      assign is_pwr[g] = pwr_on & (pwr_sel == 2'(g));
      assign hit = sample_valid & (sample_idx == 2'(g)) & in_use[g];
      // averaging only sees clean, untouched samples
      assign avg_ok[g] = hit & ~discard & ~above[g] & ~s.neg_busy[g] &
                         ~(spike[g] & s.gen_cfg[GCFG_SPIKE_BIT]);
      teq_avg #(
        .W(8),
        .N(AVG_DEPTH)
      ) u_avg (
        .sys_clk(sys_clk),
        .rst(rst),
        .sample_ok(avg_ok[g]),
        .sample_delta(sample_delta),
        .adj_valid(base_adj_valid[g]),
        .adj(base_adj[g*8 +: 8])
      );
    end
  endgenerate

  // control bit set means the blocking is switched off
  assign discard = (lf_noise & ~s.gen_cfg[GCFG_ANA_BLOCK_BIT]) |
                   (rf_noise & ~s.sec_cfg[SCFG_RF_BLOCK_BIT]);
  assign nflag = s.sec_cfg[SCFG_RADIO_ONLY_BIT] ?
                 rf_noise : (lf_noise | rf_noise);
  assign pwr_use_stby = mixed_state ? pwr_stby_en : in_standby;
  assign pwr_on = pwr_use_stby ? (pwr_stby_en & standby_en[pwr_sel]) :
                  (pwr_act_en & active_en[pwr_sel]);
  assign pwr_time = dur_ms({2'b00, pwr_use_stby ? pwr_stby_time :
                           pwr_act_time}, PWR_STEP_MS);

  // ==========================================================
  // next state
  always_comb begin
    logic ev;
    logic hitv;
    logic rise;
    logic fall;
    logic mtp_cond;
    ev = 1'b0;
    hitv = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    mtp_cond = 1'b0;
    n = s;
    n.recal_req = '0;
    n.tick = 1'b0;
    n.tick_cnt = s.tick_cnt + 1'b1;
    if (s.tick_cnt == TICK_LAST) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end
    // host clear comes first so a same-cycle event wins
    if (reg_wr && reg_addr == ADDR_MAIN_CTL && !reg_wdata[MAIN_INT_BIT]) begin
      n.int_pend = 1'b0;
      n.hold_flag = 1'b0;
      n.mtp_flag = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        ADDR_GENERAL_CONFIG: n.gen_cfg = reg_wdata;
        ADDR_SECONDARY_CONFIG: n.sec_cfg = reg_wdata;
        ADDR_INT_ENABLE: n.int_en = reg_wdata & INPUT_MASK;
        ADDR_REPEAT_ENABLE: n.rpt_en = reg_wdata & INPUT_MASK;
        default: n.gen_cfg = n.gen_cfg;
      endcase
    end
    // pattern detection works on the latest flags of each input
    mtp_cond = mtp_by_pattern ?
               ((s.mtp_hit & multi_touch_pattern) == multi_touch_pattern) :
               (ones3(s.mtp_hit) >= mtp_min_count);
    n.mtp_active = mtp_en & mtp_cond;
    if (n.mtp_active && !s.mtp_active) begin
      n.mtp_flag = 1'b1;
      ev = ev | mtp_irq_en;
    end
    for (int i = 0; i < N_IN; i++) begin
      hitv = sample_valid && sample_idx == 2'(i) && in_use[i];
      if (hitv) begin
        n.noise[i] = nflag;
        n.mtp_hit[i] = mtp_over[i] | nflag;
        if (!discard) begin
          n.touch[i] = above[i];
          if ($signed(sample_delta) < 0 && negative_reading_limit != 2'b00) begin
            n.neg_cnt[i] = s.neg_cnt[i] + 1'b1;
            if (s.neg_cnt[i] == negative_reading_limit - 1'b1) begin
              n.recal_req[i] = 1'b1;
              n.neg_busy[i] = 1'b1;
              n.neg_cnt[i] = 2'b00;
            end
          end else begin
            n.neg_cnt[i] = 2'b00;
          end
        end
      end
      if (recal_done[i]) begin
        n.neg_busy[i] = 1'b0;
        n.neg_cnt[i] = 2'b00;
      end
      if (n.neg_busy[i]) begin
        n.touch[i] = 1'b0;
      end
      if (n.mtp_active) begin
        n.touch[i] = 1'b0;
      end
      rise = n.touch[i] & ~s.touch[i];
      fall = s.touch[i] & ~n.touch[i];
      if (!is_pwr[i] && s.int_en[i]) begin
        ev = ev | rise;
        ev = ev | (fall & ~s.sec_cfg[SCFG_REL_N_BIT]);
      end
      if (!n.touch[i]) begin
        n.hold_ms[i] = '0;
        n.press_ms[i] = '0;
        n.held[i] = 1'b0;
        if (is_pwr[i]) begin
          n.pwr_ms = '0;
          n.pwr_done = 1'b0;
        end
      end else if (s.tick && s.touch[i]) begin
        if (is_pwr[i] && !s.pwr_done) begin
          n.pwr_ms = s.pwr_ms + 1'b1;
          if (n.pwr_ms >= pwr_time) begin
            n.pwr_done = 1'b1;
            n.hold_flag = 1'b1;
            ev = 1'b1;
          end
        end
        // timer only runs while touched, i.e. above threshold
        if (s.gen_cfg[GCFG_HOLD_EN_BIT] &&
            (!is_pwr[i] || s.pwr_done)) begin
          n.hold_ms[i] = s.hold_ms[i] + 1'b1;
          if (n.hold_ms[i] >= dur_ms(hold_limit_field, HOLD_STEP_MS)) begin
            n.recal_req[i] = 1'b1;
            n.hold_ms[i] = '0;
          end
        end
        if (!is_pwr[i] && s.rpt_en[i] && s.int_en[i]) begin
          n.press_ms[i] = s.press_ms[i] + 1'b1;
          if (!s.held[i] && n.press_ms[i] >=
              dur_ms(min_hold_timer_field, PRESS_STEP_MS)) begin
            n.held[i] = 1'b1;
            n.press_ms[i] = '0;
            ev = 1'b1;
          end else if (s.held[i] && n.press_ms[i] >=
                       dur_ms(repeat_rate_field, RPT_STEP_MS)) begin
            n.press_ms[i] = '0;
            ev = 1'b1;
          end
        end
      end
    end
    if (ev) begin
      n.int_pend = 1'b1;
    end
    n.alert_n = ~n.int_pend;
    // read data is captured one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MAIN_CTL: n.rd_data = 8'(s.int_pend) << MAIN_INT_BIT;
        ADDR_GEN_STATUS: n.rd_data = (8'(s.hold_flag) << STAT_HOLD_BIT) |
                                     (8'(s.mtp_flag) << STAT_MTP_BIT) |
                                     (8'(|s.touch) << STAT_TOUCH_BIT);
        ADDR_INPUT_STATUS: n.rd_data = 8'(s.touch);
        ADDR_NOISE_STATUS: n.rd_data = 8'(s.noise);
        ADDR_GENERAL_CONFIG: n.rd_data = s.gen_cfg;
        ADDR_SECONDARY_CONFIG: n.rd_data = s.sec_cfg;
        ADDR_INT_ENABLE: n.rd_data = s.int_en;
        ADDR_REPEAT_ENABLE: n.rd_data = s.rpt_en;
        default: n.rd_data = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.gen_cfg <= GEN_CFG_RST;
      s.sec_cfg <= SEC_CFG_RST;
      s.int_en <= INT_EN_RST;
      s.rpt_en <= RPT_EN_RST;
      s.alert_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = s.rd_data;
  assign alert_n = s.alert_n;
  assign recal_req = s.recal_req;
endmodule : teq_qualifier

`default_nettype wire

// file: bench/teq_chk.sv
// assertions on the qualifier ports
// assumes a bind from the bench top and one clock domain
`timescale 1ns/1ps
`default_nettype none
module teq_chk import teq_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // settings
  input wire logic in_standby,
  input wire logic [N_IN-1:0] active_en,
  input wire logic [N_IN*8-1:0] active_thr,
  input wire logic [1:0] negative_reading_limit,
  input wire logic [1:0] pwr_sel,
  input wire logic pwr_act_en,
  // measurements
  input wire logic sample_valid,
  input wire logic [1:0] sample_idx,
  input wire logic [7:0] sample_delta,
  input wire logic lf_noise,
  input wire logic rf_noise,
  // results
  input wire logic alert_n,
  input wire logic [N_IN-1:0] recal_req
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic neg1 = sample_valid && sample_idx == 2'h1 && sample_delta[7]
    && !lf_noise && !rf_noise && active_en[1] && !in_standby
    && negative_reading_limit == 2'h2;
  wire logic pwr_hit = sample_valid && sample_idx == pwr_sel && pwr_act_en
    && !in_standby && active_en[pwr_sel] && !sample_delta[7]
    && sample_delta > active_thr[pwr_sel*8 +: 8];
  wire logic host_clr = reg_wr && reg_addr == ADDR_MAIN_CTL
    && !reg_wdata[MAIN_INT_BIT];
  // ==========================================================
  // assertions
  chk_reset_idle: assert property (disable iff (1'b0)
    rst |=> alert_n && recal_req == 3'h0 && reg_rdata == 8'h00)
    else $error("outputs not idle after reset");
  chk_pin_release: assert property (
    $rose(alert_n) |-> $past(host_clr))
    else $error("alert released without host clear");
  chk_clear_pin: assert property (
    host_clr && !sample_valid && !$past(sample_valid) |=> alert_n)
    else $error("alert held after host clear");
  chk_pend_read: assert property (
    !alert_n && reg_rd && !reg_wr && reg_addr == ADDR_MAIN_CTL
    |=> reg_rdata[MAIN_INT_BIT])
    else $error("pending bit reads clear while alert low");
  chk_neg_recal: assert property (
    neg1 ##1 neg1 |=> recal_req == 3'h2)
    else $error("no recalibration after two negative readings");
  chk_recal_pulse: assert property (
    recal_req != 3'h0 |=> recal_req == 3'h0)
    else $error("recalibration request longer than one cycle");
  chk_pwr_quiet: assert property (
    pwr_hit && alert_n |=> alert_n)
    else $error("power button alerted at once");
  chk_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  // ==========================================================
  // covers
  cov_clear: cover property (host_clr ##1 alert_n);
  cov_neg: cover property (recal_req[1]);
  cov_pwr: cover property (pwr_hit ##[1:40] !alert_n);
endmodule : teq_chk
`default_nettype wire

// file: bench/teq_host_model.sv
// host model: register reads, writes and alert clears
// assumes the byte register port of the qualifier
`timescale 1ns/1ps
`default_nettype none
module teq_host_model import teq_pkg::*; (
  // clock
  input wire logic sys_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // acknowledge by writing the pending bit to zero
  task automatic clear_int;
    wr(ADDR_MAIN_CTL, 8'h00);
  endtask : clear_int
  // a release may only show on the second poll
  task automatic rd_twice(input logic [7:0] a, output logic [7:0] d);
    rd(a, d);
    rd(a, d);
  endtask : rd_twice
endmodule : teq_host_model
`default_nettype wire

// file: bench/teq_qualifier_tb_top.sv
// bench top: stimulus, host model and checks
// assumes short ticks so each timer step is ten cycles
`timescale 1ns/1ps
`default_nettype none
module teq_qualifier_tb_top import teq_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic in_standby = 1'b0, mixed_state = 1'b0, pwr_stby_en = 1'b0;
  logic pwr_act_en = 1'b0, mtp_en = 1'b0, mtp_by_pattern = 1'b1;
  logic mtp_irq_en = 1'b1, sample_valid = 1'b0, lf_noise = 1'b0;
  logic rf_noise = 1'b0;
  logic [N_IN-1:0] active_en = 3'h7, standby_en = 3'h0, recal_done = 3'h0;
  logic [N_IN-1:0] multi_touch_pattern = 3'h3;
  logic [N_IN*8-1:0] active_thr = 24'h404040;
  logic [7:0] standby_thr = 8'h40, noise_thr = 8'h10, mtp_thr = 8'h30;
  logic [7:0] sample_delta = 8'h00;
  logic [1:0] negative_reading_limit = 2'h0, pwr_sel = 2'h2;
  logic [1:0] pwr_stby_time = 2'h0, pwr_act_time = 2'h0;
  logic [1:0] mtp_min_count = 2'h2, sample_idx = 2'h0;
  logic [3:0] hold_limit_field = 4'h0, min_hold_timer_field = 4'h1;
  logic [3:0] repeat_rate_field = 4'h0;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic reg_wr, reg_rd, alert_n;
  wire logic [N_IN-1:0] recal_req;
  wire logic [N_IN-1:0] base_adj_valid;
  wire logic [N_IN*8-1:0] base_adj;
  int n_errors = 0;
  int n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  teq_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  teq_qualifier #(.TICK_CYCLES(10), .HOLD_STEP_MS(16'h0001),
    .PRESS_STEP_MS(16'h0001), .RPT_STEP_MS(16'h0001),
    .PWR_STEP_MS(16'h0001)) dut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_standby(in_standby),
    .mixed_state(mixed_state), .active_en(active_en),
    .standby_en(standby_en), .active_thr(active_thr),
    .standby_thr(standby_thr), .noise_thr(noise_thr),
    .negative_reading_limit(negative_reading_limit),
    .hold_limit_field(hold_limit_field),
    .min_hold_timer_field(min_hold_timer_field),
    .repeat_rate_field(repeat_rate_field), .pwr_sel(pwr_sel),
    .pwr_stby_en(pwr_stby_en), .pwr_act_en(pwr_act_en),
    .pwr_stby_time(pwr_stby_time), .pwr_act_time(pwr_act_time),
    .mtp_en(mtp_en), .mtp_by_pattern(mtp_by_pattern),
    .multi_touch_pattern(multi_touch_pattern),
    .mtp_min_count(mtp_min_count), .mtp_thr(mtp_thr),
    .mtp_irq_en(mtp_irq_en), .sample_valid(sample_valid),
    .sample_idx(sample_idx), .sample_delta(sample_delta),
    .lf_noise(lf_noise), .rf_noise(rf_noise), .recal_done(recal_done),
    .alert_n(alert_n), .recal_req(recal_req),
    .base_adj_valid(base_adj_valid), .base_adj(base_adj));
  // ==========================================================
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp, $sformatf("register %h", a));
  endtask : rdc
  task automatic al(input logic exp);
    chk({7'h00, alert_n}, {7'h00, exp}, "alert_n");
  endtask : al
  task automatic wait_low;
    int k;
    k = 0;
    while (k < 40 && alert_n !== 1'b0) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
  endtask : wait_low
  // back-to-back samples when n is above one
  task automatic send(input logic [1:0] i, input logic [7:0] d,
    input logic lf, input logic rf, input int n);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample_idx <= i;
    sample_delta <= d;
    lf_noise <= lf;
    rf_noise <= rf;
    repeat (n) @(posedge sys_clk);
    sample_valid <= 1'b0;
    #1;
  endtask : send
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end
  // ==========================================================
  // tests
  initial begin
    logic [7:0] d;
    int k;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(ADDR_GENERAL_CONFIG, 8'h20);
    rdc(ADDR_SECONDARY_CONFIG, 8'h00);
    rdc(ADDR_INT_ENABLE, 8'h07);
    rdc(8'h55, 8'h00);
    u_host.wr(ADDR_REPEAT_ENABLE, 8'h00);
    rdc(ADDR_REPEAT_ENABLE, 8'h00);
    send(2'h0, 8'h50, 1'b0, 1'b0, 1);
    al(1'b0);
    rdc(ADDR_INPUT_STATUS, 8'h01);
    rdc(ADDR_MAIN_CTL, 8'h01);
    u_host.clear_int();
    al(1'b1);
    send(2'h0, 8'h00, 1'b0, 1'b0, 1);
    al(1'b0);
    u_host.rd_twice(ADDR_INPUT_STATUS, d);
    chk(d, 8'h00, "release status");
    u_host.clear_int();
    // no release interrupt when the low-active option is 1
    u_host.wr(ADDR_SECONDARY_CONFIG, 8'h01);
    send(2'h0, 8'h50, 1'b0, 1'b0, 1);
    u_host.clear_int();
    send(2'h0, 8'h00, 1'b0, 1'b0, 1);
    al(1'b1);
    // noisy samples never become touches while blocking is on
    u_host.wr(ADDR_SECONDARY_CONFIG, 8'h00);
    send(2'h1, 8'h50, 1'b1, 1'b0, 1);
    rdc(ADDR_INPUT_STATUS, 8'h00);
    rdc(ADDR_NOISE_STATUS, 8'h02);
    send(2'h1, 8'h50, 1'b0, 1'b1, 1);
    rdc(ADDR_INPUT_STATUS, 8'h00);
    u_host.wr(ADDR_SECONDARY_CONFIG, 8'h80);
    send(2'h1, 8'h50, 1'b1, 1'b0, 1);
    rdc(ADDR_NOISE_STATUS, 8'h00);
    send(2'h1, 8'h50, 1'b0, 1'b1, 1);
    rdc(ADDR_NOISE_STATUS, 8'h02);
    al(1'b1);
    u_host.wr(ADDR_SECONDARY_CONFIG, 8'h00);
    // spikes stay out of the running mean of input 2
    send(2'h2, 8'h3f, 1'b0, 1'b0, 8);
    send(2'h2, 8'h04, 1'b0, 1'b0, 64);
    chk({7'h00, base_adj_valid[2]}, 8'h01, "mean valid");
    chk(base_adj[23:16], 8'h04, "mean");
    // negative run, busy window, counter restart
    @(posedge sys_clk);
    negative_reading_limit <= 2'h2;
    send(2'h1, 8'hf0, 1'b0, 1'b0, 2);
    chk({5'h00, recal_req}, 8'h02, "recal_req");
    send(2'h1, 8'h50, 1'b0, 1'b0, 1);
    rdc(ADDR_INPUT_STATUS, 8'h00);
    @(posedge sys_clk);
    recal_done <= 3'h2;
    @(posedge sys_clk);
    recal_done <= 3'h0;
    send(2'h1, 8'h50, 1'b0, 1'b0, 1);
    rdc(ADDR_INPUT_STATUS, 8'h02);
    send(2'h1, 8'hf0, 1'b0, 1'b0, 1);
    send(2'h1, 8'h00, 1'b0, 1'b0, 1);
    send(2'h1, 8'hf0, 1'b0, 1'b0, 1);
    chk({5'h00, recal_req}, 8'h00, "recal_req");
    send(2'h1, 8'h00, 1'b0, 1'b0, 1);
    u_host.clear_int();
    // pattern of inputs 0 and 1 hides both touches
    @(posedge sys_clk);
    mtp_en <= 1'b1;
    send(2'h0, 8'h50, 1'b0, 1'b0, 1);
    send(2'h1, 8'h50, 1'b0, 1'b0, 1);
    rdc(ADDR_GEN_STATUS, 8'h02);
    rdc(ADDR_INPUT_STATUS, 8'h00);
    send(2'h0, 8'h00, 1'b0, 1'b0, 1);
    send(2'h1, 8'h00, 1'b0, 1'b0, 1);
    @(posedge sys_clk);
    mtp_en <= 1'b0;
    u_host.clear_int();
    // stuck touch forces a recalibration
    u_host.wr(ADDR_GENERAL_CONFIG, 8'h28);
    send(2'h0, 8'h50, 1'b0, 1'b0, 1);
    k = 0;
    while (k < 40 && recal_req[0] !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk({7'h00, recal_req[0]}, 8'h01, "hold recal");
    send(2'h0, 8'h00, 1'b0, 1'b0, 1);
    u_host.wr(ADDR_GENERAL_CONFIG, 8'h20);
    u_host.clear_int();
    // repeat input alerts again while held
    u_host.wr(ADDR_REPEAT_ENABLE, 8'h01);
    send(2'h0, 8'h50, 1'b0, 1'b0, 1);
    u_host.clear_int();
    wait_low();
    al(1'b0);
    u_host.clear_int();
    wait_low();
    al(1'b0);
    send(2'h0, 8'h00, 1'b0, 1'b0, 1);
    u_host.wr(ADDR_REPEAT_ENABLE, 8'h00);
    u_host.clear_int();
    // power button waits for its hold time
    @(posedge sys_clk);
    pwr_act_en <= 1'b1;
    send(2'h2, 8'h50, 1'b0, 1'b0, 1);
    al(1'b1);
    wait_low();
    al(1'b0);
    u_host.rd(ADDR_GEN_STATUS, d);
    chk(d & 8'h10, 8'h10, "hold flag");
    complete_run();
  end
endmodule : teq_qualifier_tb_top
bind teq_qualifier teq_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_standby(in_standby),
  .active_en(active_en), .active_thr(active_thr),
  .negative_reading_limit(negative_reading_limit), .pwr_sel(pwr_sel),
  .pwr_act_en(pwr_act_en), .sample_valid(sample_valid),
  .sample_idx(sample_idx), .sample_delta(sample_delta),
  .lf_noise(lf_noise), .rf_noise(rf_noise), .alert_n(alert_n),
  .recal_req(recal_req));
`default_nettype wire
